// ### logic/tcc_pkg.sv
// constants, field layouts and types of the timer1 compare/control block
// ----------------------------------------------------------------------
// How it works
// - clear-on-match set: counter goes to zero the cycle after a compare A match
// - pwm enable uses compare A; counter clears the cycle after compare top match
// - outside pwm, mode 00 off, 01 toggle, 10 low, 11 high on match
// - clock select: 0 stop, 1-4 fast clock /1..8, 5-15 cpu /1..1024
// - force bit applies the pin action like a match, no flag, no interrupt
// - force uses the stored mode; outside pwm a mode written with a match is the mode applied
// - force reads zero and does nothing while pwm is enabled
// - prescaler clear resets only the prescaler, self-clears, reads zero
// - count writes land one cycle later, two cycles with the fast clock
// - matches only when counting onto the value, never from a count write
// - compare A match sets its flag after one synchronising cycle
// - with clear-on-match, a compare top match also clears the counter
// - compare A flag, its enable and global enable raise compare A request
// - overflow sets overflow flag; with enables it raises overflow request
// - compare A flag clears on vector ack or a written one, one cycle late
// - reserved bits of mask and flag registers read zero
// - overflow flag clears on vector ack or a written one, one cycle late
// - pwm mode 10 low on match, high at zero; 11 inverse; 00/01 off
// ----------------------------------------------------------------------
package tcc_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is the index times four
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_GEN_CTRL = 8'h2C;
    localparam logic [7:0] IDX_T1_CTRL = 8'h30;
    localparam logic [7:0] IDX_COUNT = 8'h31;
    localparam logic [7:0] IDX_CMP_A = 8'h32;
    localparam logic [7:0] IDX_CMP_TOP = 8'h33;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h38;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h39;

    localparam logic [7:0] ADDR_GEN_CTRL = {IDX_GEN_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_T1_CTRL = {IDX_T1_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_COUNT = {IDX_COUNT[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP_A = {IDX_CMP_A[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP_TOP = {IDX_CMP_TOP[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_FLAGS = {IDX_IRQ_FLAGS[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int FORCE_A_BIT = 2;
    localparam int PRESC_CLR_BIT = 1;
    localparam int CMP_A_IRQ_BIT = 6;
    localparam int OVF_IRQ_BIT = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // ------------------------------------------------------------------
    // clock select codes and prescaler widths
    // ------------------------------------------------------------------
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [3:0] CS_FAST_LAST = 4'h4;
    localparam logic [3:0] CS_CPU_FIRST = 4'h5;
    localparam int FAST_DIV_W = 3;
    localparam int CPU_DIV_W = 10;
    localparam logic [1:0] WR_DELAY_SYNC = 2'h1;
    localparam logic [1:0] WR_DELAY_ASYNC = 2'h2;

    typedef enum logic [1:0] {
        OUT_OFF = 2'b00,
        OUT_TOGGLE = 2'b01,
        OUT_LOW = 2'b10,
        OUT_HIGH = 2'b11
    } tcc_out_mode_t;

    typedef struct packed {
        logic clear_on_match;
        logic pwm_a_enable;
        logic cmp_a_mode_hi;
        logic cmp_a_mode_lo;
        logic [3:0] clock_source_select;
    } tcc_ctrl_t;

endpackage : tcc_pkg

// ### logic/tcc_prescaler.sv
// counter clock prescaler: fast clock and cpu clock dividers with select
`timescale 1ns/1ps
module tcc_prescaler import tcc_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic fast_en_i,
    input wire logic clear_i,
    input wire logic [3:0] select_i,
    output logic tick_o
);

    logic [FAST_DIV_W-1:0] fast_cnt_reg;
    logic [CPU_DIV_W-1:0] cpu_cnt_reg;
    logic [CPU_DIV_W-1:0] mask;
    logic tick_next;

    // ------------------------------------------------------------------
    // free-running dividers; clear leaves the timer count alone
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fast_cnt_reg <= '0;
        end else if (clear_i) begin
            fast_cnt_reg <= '0;
        end else if (fast_en_i) begin
            fast_cnt_reg <= fast_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_cnt_reg <= '0;
        end else if (clear_i) begin
            cpu_cnt_reg <= '0;
        end else begin
            cpu_cnt_reg <= cpu_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // tick selection: a divide by 2^n fires when the low n bits are ones
    // ------------------------------------------------------------------
    always_comb begin
        mask = '0;
        tick_next = 1'b0;
        if (clear_i || select_i == CS_STOP) begin
            tick_next = 1'b0;
        end else if (select_i <= CS_FAST_LAST) begin
            mask = CPU_DIV_W'((11'h1 << (select_i - 4'h1)) - 11'h1);
            tick_next = fast_en_i &&
                ((fast_cnt_reg & mask[FAST_DIV_W-1:0]) == mask[FAST_DIV_W-1:0]);
        end else begin
            mask = CPU_DIV_W'((11'h1 << (select_i - CS_CPU_FIRST)) - 11'h1);
            tick_next = ((cpu_cnt_reg & mask) == mask);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= tick_next;
        end
    end

endmodule : tcc_prescaler

// ### logic/tcc_timer1.sv
// timer1 with compare A, compare top, pin action and flags, avalon-mm slave
`timescale 1ns/1ps
module tcc_timer1 import tcc_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic fast_clk_en_i,
    input wire logic global_irq_enable_i,
    input wire logic cmp_a_vector_ack_i,
    input wire logic overflow_vector_ack_i,
    output logic cmp_a_pin_o,
    output logic cmp_a_pin_oe_o,
    output logic cmp_a_irq_o,
    output logic overflow_irq_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    tcc_ctrl_t ctrl_reg;
    logic [7:0] count_reg;
    logic [7:0] cmp_a_buf_reg;
    logic [7:0] cmp_a_reg;
    logic [7:0] cmp_top_reg;
    logic [7:0] count_wdata_reg;
    logic [1:0] wr_delay_reg;
    logic clr_pend_reg;
    logic ev_a_reg;
    logic ev_ovf_reg;
    logic cmp_a_irq_en_reg;
    logic ovf_irq_en_reg;
    logic cmp_a_flag_reg;
    logic ovf_flag_reg;
    logic clr_a_pend_reg;
    logic clr_ovf_pend_reg;
    logic [31:0] rdata_next;

    logic req;
    logic wr;
    logic [7:0] wdata;
    logic wr_gen;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_top;
    logic wr_flags;
    logic wr_mask;

    logic tick;
    logic presc_clear;
    logic load_now;
    logic counting;
    logic [7:0] count_inc;
    logic match_a;
    logic match_top;
    logic clr_now;
    logic overflow;
    logic force_a;
    logic async_src;
    tcc_out_mode_t mode_eff;

    // ------------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then the answer
    // ------------------------------------------------------------------
    assign req = avs_read_i | avs_write_i;
    assign wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign wdata = avs_writedata_i[7:0];
    assign wr_gen = wr && (avs_address_i == ADDR_GEN_CTRL);
    assign wr_ctrl = wr && (avs_address_i == ADDR_T1_CTRL);
    assign wr_count = wr && (avs_address_i == ADDR_COUNT);
    assign wr_cmp_a = wr && (avs_address_i == ADDR_CMP_A);
    assign wr_top = wr && (avs_address_i == ADDR_CMP_TOP);
    assign wr_flags = wr && (avs_address_i == ADDR_IRQ_FLAGS);
    assign wr_mask = wr && (avs_address_i == ADDR_IRQ_MASK);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (req && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // reserved and write-only bits fall through as zero
    always_comb begin
        rdata_next = '0;
        case (avs_address_i)
            ADDR_T1_CTRL: begin
                rdata_next[7:0] = ctrl_reg;
            end
            ADDR_COUNT: begin
                rdata_next[7:0] = count_reg;
            end
            ADDR_CMP_A: begin
                rdata_next[7:0] = cmp_a_buf_reg;
            end
            ADDR_CMP_TOP: begin
                rdata_next[7:0] = cmp_top_reg;
            end
            ADDR_IRQ_MASK: begin
                rdata_next[CMP_A_IRQ_BIT] = cmp_a_irq_en_reg;
                rdata_next[OVF_IRQ_BIT] = ovf_irq_en_reg;
            end
            ADDR_IRQ_FLAGS: begin
                rdata_next[CMP_A_IRQ_BIT] = cmp_a_flag_reg;
                rdata_next[OVF_IRQ_BIT] = ovf_flag_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // control, compare and mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= tcc_ctrl_t'(RST_BYTE);
        end else if (wr_ctrl) begin
            ctrl_reg <= tcc_ctrl_t'(wdata);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_top_reg <= RST_BYTE;
        end else if (wr_top) begin
            cmp_top_reg <= wdata;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_irq_en_reg <= 1'b0;
            ovf_irq_en_reg <= 1'b0;
        end else if (wr_mask) begin
            cmp_a_irq_en_reg <= wdata[CMP_A_IRQ_BIT];
            ovf_irq_en_reg <= wdata[OVF_IRQ_BIT];
        end
    end

    // in pwm mode a new compare A waits for the top so no odd pulse appears
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_buf_reg <= RST_BYTE;
        end else if (wr_cmp_a) begin
            cmp_a_buf_reg <= wdata;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_reg <= RST_BYTE;
        end else if (!ctrl_reg.pwm_a_enable || match_top) begin
            cmp_a_reg <= wr_cmp_a ? wdata : cmp_a_buf_reg;
        end
    end

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    assign presc_clear = wr_gen & wdata[PRESC_CLR_BIT];

    tcc_prescaler u_prescaler (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .fast_en_i(fast_clk_en_i),
        .clear_i(presc_clear),
        .select_i(ctrl_reg.clock_source_select),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // counter: software load, then clear, then counting
    // ------------------------------------------------------------------
    assign async_src = (ctrl_reg.clock_source_select != CS_STOP) &&
        (ctrl_reg.clock_source_select <= CS_FAST_LAST);
    assign load_now = (wr_delay_reg == WR_DELAY_SYNC);
    assign counting = tick & ~load_now & ~clr_pend_reg;
    assign count_inc = count_reg + 8'h01;
    assign match_a = counting && (count_inc == cmp_a_reg);
    assign match_top = counting && (count_inc == cmp_top_reg);
    assign clr_now = (ctrl_reg.clear_on_match && (match_a || match_top)) ||
        (ctrl_reg.pwm_a_enable && match_top);
    assign overflow = (counting && count_reg == COUNT_MAX) ||
        (ctrl_reg.pwm_a_enable && match_top);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_wdata_reg <= RST_BYTE;
            wr_delay_reg <= '0;
        end else if (wr_count) begin
            count_wdata_reg <= wdata;
            wr_delay_reg <= async_src ? WR_DELAY_ASYNC : WR_DELAY_SYNC;
        end else if (wr_delay_reg != 2'h0) begin
            wr_delay_reg <= wr_delay_reg - 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clr_pend_reg <= 1'b0;
        end else begin
            clr_pend_reg <= clr_now;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= RST_BYTE;
        end else if (load_now) begin
            count_reg <= count_wdata_reg;
        end else if (clr_pend_reg) begin
            count_reg <= RST_BYTE;
        end else if (tick) begin
            count_reg <= count_inc;
        end
    end

    // ------------------------------------------------------------------
    // compare A pin
    // ------------------------------------------------------------------
    // outside pwm a mode written in the same cycle as a match is the one applied; force uses the stored mode
    assign mode_eff = wr_ctrl ? tcc_out_mode_t'(wdata[5:4]) :
        tcc_out_mode_t'({ctrl_reg.cmp_a_mode_hi, ctrl_reg.cmp_a_mode_lo});
    assign force_a = wr_gen & wdata[FORCE_A_BIT] & ~ctrl_reg.pwm_a_enable;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_pin_oe_o <= 1'b0;
        end else if (wr_ctrl ? wdata[6] : ctrl_reg.pwm_a_enable) begin
            cmp_a_pin_oe_o <= mode_eff[1];
        end else begin
            cmp_a_pin_oe_o <= (mode_eff != OUT_OFF);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_pin_o <= 1'b0;
        end else if (ctrl_reg.pwm_a_enable) begin
            if (ctrl_reg.cmp_a_mode_hi && match_a) begin
                cmp_a_pin_o <= ctrl_reg.cmp_a_mode_lo;
            end else if (ctrl_reg.cmp_a_mode_hi && count_reg == RST_BYTE) begin
                cmp_a_pin_o <= ~ctrl_reg.cmp_a_mode_lo;
            end
        end else if (match_a || force_a) begin
            case (mode_eff)
                OUT_TOGGLE: begin
                    cmp_a_pin_o <= ~cmp_a_pin_o;
                end
                OUT_LOW: begin
                    cmp_a_pin_o <= 1'b0;
                end
                OUT_HIGH: begin
                    cmp_a_pin_o <= 1'b1;
                end
                default: begin
                    cmp_a_pin_o <= cmp_a_pin_o;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // flags: events pass one sync stage; a set beats a same-cycle clear
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev_a_reg <= 1'b0;
            ev_ovf_reg <= 1'b0;
        end else begin
            ev_a_reg <= match_a;
            ev_ovf_reg <= overflow;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clr_a_pend_reg <= 1'b0;
            clr_ovf_pend_reg <= 1'b0;
        end else begin
            clr_a_pend_reg <= wr_flags & wdata[CMP_A_IRQ_BIT];
            clr_ovf_pend_reg <= wr_flags & wdata[OVF_IRQ_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_flag_reg <= 1'b0;
        end else if (ev_a_reg) begin
            cmp_a_flag_reg <= 1'b1;
        end else if (clr_a_pend_reg || cmp_a_vector_ack_i) begin
            cmp_a_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovf_flag_reg <= 1'b0;
        end else if (ev_ovf_reg) begin
            ovf_flag_reg <= 1'b1;
        end else if (clr_ovf_pend_reg || overflow_vector_ack_i) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests to the cpu
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_a_irq_o <= 1'b0;
            overflow_irq_o <= 1'b0;
        end else begin
            cmp_a_irq_o <= cmp_a_flag_reg & cmp_a_irq_en_reg & global_irq_enable_i;
            overflow_irq_o <= ovf_flag_reg & ovf_irq_en_reg & global_irq_enable_i;
        end
    end

endmodule : tcc_timer1

// ### sim/tcc_timer1_monitor.sv
// assertion checker for the timer1 compare/control block
`timescale 1ns/1ps
module tcc_timer1_monitor import tcc_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic global_irq_enable_i,
    input wire logic cmp_a_pin_o,
    input wire logic cmp_a_pin_oe_o,
    input wire logic cmp_a_irq_o,
    input wire logic overflow_irq_o
);
    // ------------------------------------------------------------
    // shadow of the control byte, taken when a write completes
    // ------------------------------------------------------------
    logic wr_done;
    logic frc;
    logic pin_off;
    logic [7:0] ctrl_reg;
    assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign frc = wr_done && avs_address_i == ADDR_GEN_CTRL && avs_writedata_i[FORCE_A_BIT];
    assign pin_off = !ctrl_reg[5] && (!ctrl_reg[4] || ctrl_reg[6]);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= 8'h00;
        end else if (wr_done && avs_address_i == ADDR_T1_CTRL) begin
            ctrl_reg <= avs_writedata_i[7:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    property p_cmp_irq; cmp_a_irq_o |-> $past(global_irq_enable_i); endproperty
    a_cmp_irq: assert property (p_cmp_irq)
        else $error("compare irq without global enable");
    property p_ovf_irq; overflow_irq_o |-> $past(global_irq_enable_i); endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow irq without global enable");
    property p_rsvd;
        avs_read_i && !avs_waitrequest_o
            && (avs_address_i == ADDR_IRQ_MASK || avs_address_i == ADDR_IRQ_FLAGS)
            |-> avs_readdata_o[7] == 1'b0 && avs_readdata_o[0] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit read as one");
    property p_gen_zero;
        avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_GEN_CTRL
            |-> avs_readdata_o == 32'h00000000;
    endproperty
    a_gen_zero: assert property (p_gen_zero)
        else $error("general control read not zero");
    property p_oe_off; pin_off && $past(pin_off) |-> !cmp_a_pin_oe_o; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pin driven while disconnected");
    property p_force_hi; frc && ctrl_reg[6:4] == 3'b011 |=> cmp_a_pin_o; endproperty
    a_force_hi: assert property (p_force_hi)
        else $error("forced set did not drive pin high");
    property p_force_lo; frc && ctrl_reg[6:4] == 3'b010 |=> !cmp_a_pin_o; endproperty
    a_force_lo: assert property (p_force_lo)
        else $error("forced clear did not drive pin low");
    property p_force_pwm;
        frc && ctrl_reg[6] && ctrl_reg[3:0] == 4'h0 |=> $stable(cmp_a_pin_o);
    endproperty
    a_force_pwm: assert property (p_force_pwm)
        else $error("force acted in pwm mode");
    property p_ovf_clr;
        wr_done && avs_address_i == ADDR_IRQ_FLAGS && avs_writedata_i[OVF_IRQ_BIT]
            && ctrl_reg[3:0] == 4'h0 |-> ##3 !overflow_irq_o;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr)
        else $error("overflow flag not cleared by write");
    property p_rst;
        $rose(resetn_i) |-> avs_waitrequest_o && !cmp_a_pin_oe_o && !cmp_a_irq_o;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not idle after reset");
endmodule : tcc_timer1_monitor

bind tcc_timer1 tcc_timer1_monitor u_tcc_timer1_monitor (
    .clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .global_irq_enable_i(global_irq_enable_i),
    .cmp_a_pin_o(cmp_a_pin_o), .cmp_a_pin_oe_o(cmp_a_pin_oe_o), .cmp_a_irq_o(cmp_a_irq_o),
    .overflow_irq_o(overflow_irq_o)
);

// ### sim/tcc_timer1_tb.sv
// self-checking testbench for the timer1 compare/control block
`timescale 1ns/1ps
module tcc_timer1_tb import tcc_pkg::*;;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic fast_clk_en_i = 1'b0;
    logic global_irq_enable_i = 1'b0;
    logic cmp_a_vector_ack_i = 1'b0;
    logic overflow_vector_ack_i = 1'b0;
    logic cmp_a_pin_o;
    logic cmp_a_pin_oe_o;
    logic cmp_a_irq_o;
    logic overflow_irq_o;
    logic [7:0] rd;
    int miscompares = 0, checked = 0, cycles = 0;
    int dv, lo, hi, n;
    logic [7:0] addrs [7] = '{ADDR_GEN_CTRL, ADDR_T1_CTRL, ADDR_COUNT, ADDR_CMP_A,
                              ADDR_CMP_TOP, ADDR_IRQ_FLAGS, ADDR_IRQ_MASK};
    logic [7:0] fmode [6] = '{8'h30, 8'h20, 8'h10, 8'h10, 8'h00, 8'h70};
    logic [7:0] fpin [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] cc [3] = '{8'h85, 8'h85, 8'h65};
    logic [7:0] ca [3] = '{8'h03, 8'hC8, 8'hC8};
    logic [7:0] ct [3] = '{8'hC8, 8'h05, 8'h06};

    tcc_timer1 u_tcc_timer1 (
        .clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .fast_clk_en_i(fast_clk_en_i), .global_irq_enable_i(global_irq_enable_i),
        .cmp_a_vector_ack_i(cmp_a_vector_ack_i), .overflow_vector_ack_i(overflow_vector_ack_i),
        .cmp_a_pin_o(cmp_a_pin_o), .cmp_a_pin_oe_o(cmp_a_pin_oe_o),
        .cmp_a_irq_o(cmp_a_irq_o), .overflow_irq_o(overflow_irq_o)
    );
    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) fast_clk_en_i <= ~fast_clk_en_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // bus and checking tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // an idle edge after release keeps calls apart
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        avs_address_i <= addr;
        avs_writedata_i <= {24'h000000, wd};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus
    task automatic wr(input logic [7:0] addr, input logic [7:0] wd);
        bus(1'b1, addr, wd);
    endtask : wr
    task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        bus(1'b0, addr, 8'h00);
        check(name, rd, exp);
    endtask : rdchk

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        foreach (addrs[i]) rdchk("reset value", addrs[i], 8'h00);
        rdchk("unmapped", 8'h00, 8'h00);
        wr(ADDR_IRQ_MASK, 8'hFF);
        rdchk("mask", ADDR_IRQ_MASK, 8'h44);
        wr(ADDR_COUNT, 8'h5A);
        rdchk("count", ADDR_COUNT, 8'h5A);
        for (int s = 0; s < 16; s++) begin
            dv = (s == 0) ? 1 : (s < 5) ? (2 << (s - 1)) : (1 << (s - 5));
            lo = (s == 0) ? 0 : 7;
            hi = (s == 0) ? 0 : 9;
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_GEN_CTRL, 8'h02);
            wr(ADDR_T1_CTRL, 8'(s));
            repeat (8 * dv - 3) @(posedge clock_i);
            wr(ADDR_T1_CTRL, 8'h00);
            bus(1'b0, ADDR_COUNT, 8'h00);
            check("ticks", 8'(rd >= lo && rd <= hi), 8'h01);
        end
        rdchk("general", ADDR_GEN_CTRL, 8'h00);
        wr(ADDR_COUNT, 8'h05);
        foreach (fmode[i]) begin
            wr(ADDR_T1_CTRL, fmode[i]);
            wr(ADDR_GEN_CTRL, 8'h04);
            check("pin", {7'h00, cmp_a_pin_o}, fpin[i]);
            check("oe", {7'h00, cmp_a_pin_oe_o}, {7'h00, fmode[i][5:4] != 2'b00});
        end
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_CMP_A, 8'h10);
        wr(ADDR_COUNT, 8'h10);
        global_irq_enable_i <= 1'b1;
        wr(ADDR_IRQ_MASK, 8'h44);
        wr(ADDR_T1_CTRL, 8'h05);
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h00);
        n = 0;
        while (overflow_irq_o !== 1'b1 && n < 300) begin
            @(posedge clock_i);
            n++;
        end
        check("ovf irq", {7'h00, overflow_irq_o}, 8'h01);
        n = 0;
        while (cmp_a_irq_o !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            n++;
        end
        check("cmp irq", {7'h00, cmp_a_irq_o}, 8'h01);
        wr(ADDR_T1_CTRL, 8'h00);
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h44);
        cmp_a_vector_ack_i <= 1'b1;
        @(posedge clock_i);
        cmp_a_vector_ack_i <= 1'b0;
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h04);
        wr(ADDR_IRQ_FLAGS, 8'h04);
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h00);
        check("irqs", {6'h00, cmp_a_irq_o, overflow_irq_o}, 8'h00);
        foreach (cc[i]) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CMP_A, ca[i]);
            wr(ADDR_CMP_TOP, ct[i]);
            wr(ADDR_T1_CTRL, cc[i]);
            repeat (37) @(posedge clock_i);
            wr(ADDR_T1_CTRL, 8'h00);
            bus(1'b0, ADDR_COUNT, 8'h00);
            check("wrap", 8'(rd <= ((i == 0) ? ca[i] : ct[i])), 8'h01);
        end
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h44);
        overflow_vector_ack_i <= 1'b1;
        @(posedge clock_i);
        overflow_vector_ack_i <= 1'b0;
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h40);
        wr(ADDR_IRQ_FLAGS, 8'h40);
        rdchk("flags", ADDR_IRQ_FLAGS, 8'h00);
        end_of_test();
    end
endmodule : tcc_timer1_tb
